// File: hdl/optical_mgmt_map.vh
`ifndef OPTICAL_MGMT_MAP_VH
`define OPTICAL_MGMT_MAP_VH
// ----------------------------------------------------------------------------
// Two-wire slave addressing
// ----------------------------------------------------------------------------
`define DEV_ADDR         7'h50
`define ADDR_W           8
`define ADDR_START       8'h00
// ----------------------------------------------------------------------------
// Memory map of the diagnostics controller
// ----------------------------------------------------------------------------
`define OFS_TEMP         8'h60
`define OFS_BIAS         8'h62
`define OFS_TXPWR        8'h64
`define OFS_RXPWR        8'h66
`define OFS_VCC          8'h68
`define OFS_ALARM        8'h50
`define OFS_WARN         8'h52
`define OFS_WP_LIMIT     8'h60
// ----------------------------------------------------------------------------
// Alarm and warning limit defaults (high, low)
// ----------------------------------------------------------------------------
`define LIM_ALM_HI       16'hf000
`define LIM_ALM_LO       16'h0100
`define LIM_WRN_HI       16'he000
`define LIM_WRN_LO       16'h0200
// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define CLK_PERIOD_NS    8
`define LASER_TIME_MS    100
`define NS_PER_MS        1000000
`define LASER_SETTLE_DIV 1000
`define INIT_CYCLES      16
`define BYTE_BITS        4'd8
`endif

// File: hdl/limit_check.v
`timescale 1ns/1ps
// Compares one monitored value against alarm and warning windows
module limit_check
(
   // Clock and reset
   input  wire        clk,
   input  wire        rst,
   // Monitored value
   input  wire [15:0] value,
   // Flags
   output reg         alarm_hi_r,
   output reg         alarm_lo_r,
   output reg         warn_hi_r,
   output reg         warn_lo_r
);
`include "optical_mgmt_map.vh"

   // ------------------------------------------------------------------------
   // Flag evaluation
   // ------------------------------------------------------------------------
   // Flags follow the value every cycle
   always @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         alarm_hi_r <= 1'b0;
         alarm_lo_r <= 1'b0;
         warn_hi_r  <= 1'b0;
         warn_lo_r  <= 1'b0;
      end
      else
      begin
         alarm_hi_r <= (value > `LIM_ALM_HI);
         alarm_lo_r <= (value < `LIM_ALM_LO);
         warn_hi_r  <= (value > `LIM_WRN_HI);
         warn_lo_r  <= (value < `LIM_WRN_LO);
      end
   end
endmodule

// File: hdl/optical_module_control_mgmt.v
`timescale 1ns/1ps
`include "optical_mgmt_map.vh"
module optical_module_control_mgmt
#(
   parameter LASER_CYCLES = (`LASER_TIME_MS * `NS_PER_MS) / `CLK_PERIOD_NS,
   parameter MEM_DEPTH    = 256
)
(
   // Clock and reset
   input  wire        clk,
   input  wire        rst,
   // Host control pins
   input  wire        module_deselect,
   input  wire        laser_off_request,
   input  wire        power_down,
   // Host status pins
   output reg         interrupt_n_r,
   output reg         module_absent_r,
   output reg         module_not_ready_r,
   output reg         receive_signal_lost_r,
   // Two-wire link
   input  wire        scl_in,
   input  wire        sda_in,
   output reg         sda_oe_r,
   // Optical front end
   input  wire        rx_signal_detect,
   output reg         laser_enable_r,
   output reg         standby_r,
   // Monitor values
   input  wire [15:0] mon_temp,
   input  wire [15:0] mon_bias,
   input  wire [15:0] mon_txpwr,
   input  wire [15:0] mon_rxpwr,
   input  wire [15:0] mon_vcc
);

   // ------------------------------------------------------------------------
   // Input synchronisers
   // ------------------------------------------------------------------------
   reg  [1:0] scl_s, sda_s, sel_s, dis_s, pd_s, sd_s; // Two-stage chains
   reg        scl_d, sda_d, pd_d;                     // Previous samples
   always @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         scl_s <= 2'h3; sda_s <= 2'h3; sel_s <= 2'h3;
         dis_s <= 2'h3; pd_s  <= 2'h0; sd_s  <= 2'h0;
         scl_d <= 1'b1; sda_d <= 1'b1; pd_d  <= 1'b0;
      end
      else
      begin
         scl_s <= {scl_s[0], scl_in};
         sda_s <= {sda_s[0], sda_in};
         sel_s <= {sel_s[0], module_deselect};
         dis_s <= {dis_s[0], laser_off_request};
         pd_s  <= {pd_s[0], power_down};
         sd_s  <= {sd_s[0], rx_signal_detect};
         scl_d <= scl_s[1];
         sda_d <= sda_s[1];
         pd_d  <= pd_s[1];
      end
   end
   wire scl_rise = scl_s[1] & ~scl_d;
   wire scl_fall = ~scl_s[1] & scl_d;
   wire start_c  = scl_s[1] & scl_d & sda_d & ~sda_s[1];
   wire stop_c   = scl_s[1] & scl_d & ~sda_d & sda_s[1];
   wire pd_fall  = pd_d & ~pd_s[1];
   wire soft_rst = pd_fall | pd_s[1];

   // ------------------------------------------------------------------------
   // Initialisation and laser timing
   // ------------------------------------------------------------------------
   reg [7:0]  init_cnt_r;   // Post-reset settling counter
   reg [31:0] las_cnt_r;    // Laser transition counter
   reg        las_tgt_r;    // Requested laser state
   always @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         init_cnt_r <= 8'h00; module_not_ready_r <= 1'b1;
         las_cnt_r <= 32'h0; las_tgt_r <= 1'b0; laser_enable_r <= 1'b0;
         standby_r <= 1'b0; module_absent_r <= 1'b0;
      end
      else
      begin
         module_absent_r <= 1'b0;
         standby_r <= pd_s[1];
         if (soft_rst)
         begin
            init_cnt_r <= 8'h00;
            module_not_ready_r <= 1'b1;
            laser_enable_r <= 1'b0;
            las_tgt_r <= 1'b0;
         end
         else if (init_cnt_r != `INIT_CYCLES)
            init_cnt_r <= init_cnt_r + 8'h01;
         else
         begin
            module_not_ready_r <= 1'b0;
            // Laser drops at once on disable and returns after a short settle, well inside the limit
            if (las_tgt_r != ~dis_s[1])
            begin
               las_tgt_r <= ~dis_s[1];
               las_cnt_r <= 32'h0;
               if (dis_s[1])
                  laser_enable_r <= 1'b0;
            end
            else if (las_cnt_r < LASER_CYCLES / `LASER_SETTLE_DIV)
               las_cnt_r <= las_cnt_r + 32'h1;
            else
               laser_enable_r <= las_tgt_r;
         end
      end
   end

   // ------------------------------------------------------------------------
   // Monitoring and flags
   // ------------------------------------------------------------------------
   wire [4:0] ah, al, wh, wl;
   wire [79:0] mons = {mon_vcc, mon_rxpwr, mon_txpwr, mon_bias, mon_temp};
   genvar gi;
   generate
      for (gi = 0; gi < 5; gi = gi + 1)
      begin : g_lim
         limit_check u_lim
         (
            .clk        (clk),
            .rst        (rst),
            .value      (mons[gi*16 +: 16]),
            .alarm_hi_r (ah[gi]),
            .alarm_lo_r (al[gi]),
            .warn_hi_r  (wh[gi]),
            .warn_lo_r  (wl[gi])
         );
      end
   endgenerate
   always @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         interrupt_n_r <= 1'b1;
         receive_signal_lost_r <= 1'b1;
      end
      else
      begin
         interrupt_n_r <= ~(|{ah, al, wh, wl});
         receive_signal_lost_r <= ~sd_s[1];
      end
   end

   // ------------------------------------------------------------------------
   // Diagnostics memory and read mux
   // ------------------------------------------------------------------------
   reg [7:0] mem [0:MEM_DEPTH-1];  // User-writable bytes, 8-bit words
   reg [7:0] addr_r;               // Current byte pointer
   reg [7:0] rdata;                // Byte at pointer
   always @*
   begin
      case (addr_r)
         `OFS_TEMP:       rdata = mon_temp[15:8];
         `OFS_TEMP+8'h1:  rdata = mon_temp[7:0];
         `OFS_BIAS:       rdata = mon_bias[15:8];
         `OFS_BIAS+8'h1:  rdata = mon_bias[7:0];
         `OFS_TXPWR:      rdata = mon_txpwr[15:8];
         `OFS_TXPWR+8'h1: rdata = mon_txpwr[7:0];
         `OFS_RXPWR:      rdata = mon_rxpwr[15:8];
         `OFS_RXPWR+8'h1: rdata = mon_rxpwr[7:0];
         `OFS_VCC:        rdata = mon_vcc[15:8];
         `OFS_VCC+8'h1:   rdata = mon_vcc[7:0];
         `OFS_ALARM:      rdata = {ah, al[4:2]};
         `OFS_ALARM+8'h1: rdata = {al[1:0], 6'h00};
         `OFS_WARN:       rdata = {wh, wl[4:2]};
         `OFS_WARN+8'h1:  rdata = {wl[1:0], 6'h00};
         default:         rdata = mem[addr_r];
      endcase
   end

   // ------------------------------------------------------------------------
   // Two-wire slave state machine
   // ------------------------------------------------------------------------
   localparam S_IDLE = 6'h01, S_DEV = 6'h02, S_DACK = 6'h04;
   localparam S_WR   = 6'h08, S_RD  = 6'h10, S_RACK = 6'h20;
   reg [5:0] st_r;        // One-hot state
   reg [3:0] bit_r;       // Bit counter
   reg [7:0] sh_r;        // Shift register
   reg       rw_r;        // Read direction
   reg       first_r;     // Next write byte is address
   integer   k;
   always @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         st_r <= S_IDLE; bit_r <= 4'h0; sh_r <= 8'h00; rw_r <= 1'b0;
         first_r <= 1'b0; sda_oe_r <= 1'b0;
         addr_r <= `ADDR_START;
         for (k = 0; k < MEM_DEPTH; k = k + 1)
            mem[k] <= 8'h00;
      end
      else if (soft_rst | sel_s[1] | stop_c)
      begin
         st_r <= S_IDLE; sda_oe_r <= 1'b0;
         if (soft_rst)
         begin
            addr_r <= `ADDR_START;
            // Power-down restart wipes user bytes as a power cycle would
            for (k = 0; k < MEM_DEPTH; k = k + 1)
               mem[k] <= 8'h00;
         end
      end
      else if (start_c)
      begin
         st_r <= S_DEV; bit_r <= 4'h0; sda_oe_r <= 1'b0;
      end
      else
      begin
         case (st_r)
            S_IDLE: ;
            S_DEV, S_WR:
               if (scl_rise)
               begin
                  sh_r <= {sh_r[6:0], sda_s[1]};
                  bit_r <= bit_r + 4'h1;
               end
               else if (scl_fall && bit_r == `BYTE_BITS)
               begin
                  bit_r <= 4'h0;
                  if (st_r == S_DEV)
                  begin
                     if (sh_r[7:1] == `DEV_ADDR)
                     begin
                        sda_oe_r <= 1'b1;
                        rw_r <= sh_r[0];
                        first_r <= 1'b1;
                        st_r <= S_DACK;
                     end
                     else
                        st_r <= S_IDLE;
                  end
                  else
                  begin
                     sda_oe_r <= 1'b1;
                     st_r <= S_DACK;
                     first_r <= 1'b0;
                     if (first_r)
                        addr_r <= sh_r;
                     else
                     begin
                        if (addr_r >= `OFS_WP_LIMIT || addr_r < `OFS_ALARM)
                           mem[addr_r] <= sh_r;
                        addr_r <= addr_r + 8'h01;
                     end
                  end
               end
            S_DACK:
               if (scl_fall)
               begin
                  if (rw_r)
                  begin
                     sda_oe_r <= ~rdata[7];
                     sh_r <= {rdata[6:0], 1'b0};
                     bit_r <= 4'h1;
                     st_r <= S_RD;
                  end
                  else
                  begin
                     sda_oe_r <= 1'b0;
                     st_r <= S_WR;
                  end
               end
            S_RD:
               if (scl_fall)
               begin
                  if (bit_r == `BYTE_BITS)
                  begin
                     sda_oe_r <= 1'b0;
                     addr_r <= addr_r + 8'h01;
                     st_r <= S_RACK;
                  end
                  else
                  begin
                     sda_oe_r <= ~sh_r[7];
                     sh_r <= {sh_r[6:0], 1'b0};
                     bit_r <= bit_r + 4'h1;
                  end
               end
            S_RACK:
               if (scl_rise)
               begin
                  if (sda_s[1])
                     st_r <= S_IDLE;                       // Host nack ends read
                  else
                     st_r <= S_DACK;
               end
            default: st_r <= S_IDLE;
         endcase
      end
   end
endmodule

// File: verif/two_wire_host.sv
`timescale 1ns/1ps
// ------
// Host side two-wire master, open drain on data
// ------
module two_wire_host
(
   // Wire side
   output logic scl,
   output logic sda_low,
   input  logic sda_in
);
   initial
   begin
      scl = 1'b1; // Clock stands high between frames
      sda_low = 1'b0;
   end
   // Start or repeated start: data falls while clock high
   task start;
   begin
      sda_low = 1'b0;
      #40 scl = 1'b1;
      #40 sda_low = 1'b1;
      #40 scl = 1'b0;
   end
   endtask
   // Stop: data rises while clock high
   task stop;
   begin
      #40 sda_low = 1'b1;
      #40 scl = 1'b1;
      #40 sda_low = 1'b0;
      #40;
   end
   endtask
   // Send one byte MSB first, ack is the level seen in the ninth bit
   task put(input logic [7:0] b, output logic ack);
   begin
      for (int i = 7; i >= 0; i--)
      begin
         #40 sda_low = ~b[i];
         #40 scl = 1'b1;
         #80 scl = 1'b0;
      end
      #40 sda_low = 1'b0;
      #40 scl = 1'b1;
      #40 ack = sda_in;
      #40 scl = 1'b0;
   end
   endtask
   // Take one byte, sampled mid high phase, then answer ack or nack
   task get(input logic nack, output logic [7:0] b);
   begin
      for (int i = 0; i < 8; i++)
      begin
         sda_low = 1'b0;
         #80 scl = 1'b1;
         #40 b = {b[6:0], sda_in};
         #40 scl = 1'b0;
      end
      #40 sda_low = ~nack;
      #40 scl = 1'b1;
      #80 scl = 1'b0;
   end
   endtask
endmodule

// File: verif/optical_mgmt_properties.sv
`timescale 1ns/1ps
`include "optical_mgmt_map.vh"
module optical_mgmt_properties
#(
   parameter int LASER_CYCLES = 2000
)
(
   // Clock and reset
   input logic        clk,
   input logic        rst,
   // Host pins
   input logic        module_deselect,
   input logic        laser_off_request,
   input logic        power_down,
   input logic        interrupt_n_r,
   input logic        module_absent_r,
   input logic        module_not_ready_r,
   input logic        receive_signal_lost_r,
   // Link and front end
   input logic        scl_in,
   input logic        sda_oe_r,
   input logic        rx_signal_detect,
   input logic        laser_enable_r,
   input logic        standby_r,
   input logic [15:0] mon_temp
);
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   int unsigned dark_cnt_r; // Cycles the laser is off with no cause
   int unsigned init_cnt_r; // Cycles not ready outside standby
   // Counters for the long waits
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         dark_cnt_r <= 0;
         init_cnt_r <= 0;
      end
      else
      begin
         dark_cnt_r <= (laser_off_request || laser_enable_r || power_down) ? 0 : dark_cnt_r + 1;
         init_cnt_r <= (module_not_ready_r && !power_down) ? init_cnt_r + 1 : 0;
      end
   end
   sequence desel_held; module_deselect [*8]; endsequence
   sequence pd_held; power_down [*6]; endsequence
   sequence rx_steady; $stable(rx_signal_detect) [*6]; endsequence
   sequence hot_temp;
      (mon_temp > `LIM_ALM_HI && !power_down && !module_not_ready_r) [*6];
   endsequence
   a_absent_grounded: assert property (!module_absent_r)
      else $error("module absent output not low");
   a_deselect_quiet: assert property (desel_held |-> !$rose(sda_oe_r))
      else $error("ack driven while deselected");
   a_alarm_interrupt: assert property (hot_temp |-> !interrupt_n_r)
      else $error("interrupt not raised on alarm");
   a_laser_off: assert property (laser_off_request [*5] |-> !laser_enable_r)
      else $error("laser on while disabled");
   a_laser_on_time: assert property (dark_cnt_r <= LASER_CYCLES)
      else $error("laser late to turn on");
   a_loss_level: assert property (rx_steady |-> receive_signal_lost_r == !rx_signal_detect)
      else $error("loss of signal level wrong");
   a_standby_hold: assert property (pd_held |-> standby_r && module_not_ready_r)
      else $error("power down not holding standby");
   a_init_bound: assert property (init_cnt_r <= 64)
      else $error("not ready held too long");
   a_oe_on_fall: assert property ($changed(sda_oe_r) |-> !scl_in && !$past(scl_in))
      else $error("data driven outside clock low");
endmodule
bind optical_module_control_mgmt optical_mgmt_properties #(.LASER_CYCLES(LASER_CYCLES)) chk_u
(
   .clk(clk), .rst(rst), .module_deselect(module_deselect),
   .laser_off_request(laser_off_request), .power_down(power_down),
   .interrupt_n_r(interrupt_n_r), .module_absent_r(module_absent_r),
   .module_not_ready_r(module_not_ready_r), .receive_signal_lost_r(receive_signal_lost_r),
   .scl_in(scl_in), .sda_oe_r(sda_oe_r), .rx_signal_detect(rx_signal_detect),
   .laser_enable_r(laser_enable_r), .standby_r(standby_r), .mon_temp(mon_temp)
);

// File: verif/tb_optical_module_control_mgmt.sv
`timescale 1ns/1ps
module tb_optical_module_control_mgmt;
   localparam int LASER_CYCLES = 2000; // Shortened laser settle bound
   logic clk = 1'b0, rst = 1'b1, module_deselect = 1'b0, laser_off_request = 1'b0;
   logic power_down = 1'b0, rx_signal_detect = 1'b1, scl, host_low, k;
   logic [15:0] mon_temp = 16'h4000, mon_vcc = 16'h4000;
   logic [7:0]  d0, d1;
   wire interrupt_n_r, module_absent_r, module_not_ready_r, receive_signal_lost_r;
   wire sda_oe_r, laser_enable_r, standby_r;
   wire sda_in = !(host_low || sda_oe_r); // Pull-up wins when nobody pulls low
   int  n_mismatch = 0;
   int  comparisons = 0;
   always #4 clk = ~clk;
   optical_module_control_mgmt #(.LASER_CYCLES(LASER_CYCLES)) dut_u
   (
      .clk(clk), .rst(rst), .module_deselect(module_deselect),
      .laser_off_request(laser_off_request), .power_down(power_down),
      .interrupt_n_r(interrupt_n_r), .module_absent_r(module_absent_r),
      .module_not_ready_r(module_not_ready_r), .receive_signal_lost_r(receive_signal_lost_r),
      .scl_in(scl), .sda_in(sda_in), .sda_oe_r(sda_oe_r), .rx_signal_detect(rx_signal_detect),
      .laser_enable_r(laser_enable_r), .standby_r(standby_r), .mon_temp(mon_temp),
      .mon_bias(16'h4000), .mon_txpwr(16'h4000), .mon_rxpwr(16'h4000), .mon_vcc(mon_vcc)
   );
   two_wire_host host_u (.scl(scl), .sda_low(host_low), .sda_in(sda_in));
   // ------
   // Shared tasks
   // ------
   task chk(input logic [7:0] got, input logic [7:0] exp);
   begin
      comparisons++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   end
   endtask
   task final_report;
   begin
      if (n_mismatch == 0 && comparisons > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   end
   endtask
   // Pointer write plus two data bytes
   task wr(input logic [7:0] a, input logic [7:0] b0, input logic [7:0] b1);
   begin
      host_u.start();
      host_u.put(8'ha0, k);
      chk({7'h0, k}, 8'h00);
      host_u.put(a, k);
      chk({7'h0, k}, 8'h00);
      host_u.put(b0, k);
      host_u.put(b1, k);
      host_u.stop();
   end
   endtask
   // Random read of two bytes through a repeated start
   task rd2(input logic [7:0] a);
   begin
      host_u.start();
      host_u.put(8'ha0, k);
      host_u.put(a, k);
      host_u.start();
      host_u.put(8'ha1, k);
      chk({7'h0, k}, 8'h00);
      host_u.get(1'b0, d0);
      host_u.get(1'b1, d1);
      host_u.stop();
   end
   endtask
   task wait_ready;
   begin
      for (int i = 0; i < 64 && module_not_ready_r !== 1'b0; i++) @(negedge clk);
      chk({7'h0, module_not_ready_r}, 8'h00);
   end
   endtask
   // ------
   // Scenarios
   // ------
   // Status pins straight after reset, then ready in time
   task t_reset;
   begin
      chk({7'h0, module_absent_r}, 8'h00);
      chk({7'h0, module_not_ready_r}, 8'h01);
      wait_ready();
      chk({7'h0, interrupt_n_r}, 8'h01);
   end
   endtask
   // Sequential write and read back; protected RAM bytes stay clear
   task t_memory;
   begin
      wr(8'h00, 8'ha5, 8'h3c);
      rd2(8'h00);
      chk(d0, 8'ha5);
      chk(d1, 8'h3c);
      wr(8'h5e, 8'hff, 8'hff);
      rd2(8'h5e);
      chk(d0, 8'h00);
      chk(d1, 8'h00);
   end
   endtask
   // Live monitor values, high byte first
   task t_monitors;
   begin
      mon_temp = 16'h1234;
      mon_vcc = 16'h8081;
      repeat (4) @(negedge clk);
      rd2(8'h60);
      chk(d0, 8'h12);
      chk(d1, 8'h34);
      rd2(8'h68);
      chk(d0, 8'h80);
      chk(d1, 8'h81);
   end
   endtask
   // Warning band only, then over the alarm limit, then back inside
   task t_flags;
   begin
      mon_temp = 16'he800;
      repeat (8) @(negedge clk);
      chk({7'h0, interrupt_n_r}, 8'h00);
      rd2(8'h50);
      chk(d0 | d1, 8'h00);
      rd2(8'h52);
      chk({7'h0, (d0 | d1) != 8'h00}, 8'h01);
      mon_temp = 16'hf800;
      repeat (8) @(negedge clk);
      chk({7'h0, interrupt_n_r}, 8'h00);
      rd2(8'h50);
      chk({7'h0, (d0 | d1) != 8'h00}, 8'h01);
      mon_temp = 16'h4000;
      repeat (8) @(negedge clk);
      chk({7'h0, interrupt_n_r}, 8'h01);
   end
   endtask
   // Deselected module and a foreign address get no ack
   task t_select;
   begin
      module_deselect = 1'b1;
      repeat (8) @(negedge clk);
      host_u.start();
      host_u.put(8'ha0, k);
      chk({7'h0, k}, 8'h01);
      host_u.stop();
      module_deselect = 1'b0;
      repeat (8) @(negedge clk);
      host_u.start();
      host_u.put(8'ha2, k);
      chk({7'h0, k}, 8'h01);
      host_u.stop();
   end
   endtask
   // Laser off request and release
   task t_laser;
   begin
      laser_off_request = 1'b1;
      repeat (8) @(negedge clk);
      chk({7'h0, laser_enable_r}, 8'h00);
      laser_off_request = 1'b0;
      for (int i = 0; i < LASER_CYCLES && laser_enable_r !== 1'b1; i++) @(negedge clk);
      chk({7'h0, laser_enable_r}, 8'h01);
   end
   endtask
   // Loss of optical input and its return
   task t_loss;
   begin
      rx_signal_detect = 1'b0;
      repeat (8) @(negedge clk);
      chk({7'h0, receive_signal_lost_r}, 8'h01);
      rx_signal_detect = 1'b1;
      repeat (8) @(negedge clk);
      chk({7'h0, receive_signal_lost_r}, 8'h00);
   end
   endtask
   // Standby, then full reset on the falling edge, RAM wiped
   task t_power_down;
   begin
      power_down = 1'b1;
      repeat (8) @(negedge clk);
      chk({7'h0, standby_r}, 8'h01);
      chk({7'h0, laser_enable_r}, 8'h00);
      power_down = 1'b0;
      repeat (4) @(negedge clk);
      chk({7'h0, module_not_ready_r}, 8'h01);
      wait_ready();
      rd2(8'h60);
      chk(d0, 8'h40);
      rd2(8'h00);
      chk(d0, 8'h00);
   end
   endtask
   initial
   begin
      repeat (2) @(negedge clk);
      rst = 1'b0;
      t_reset();
      t_memory();
      t_monitors();
      t_flags();
      t_select();
      t_laser();
      t_loss();
      t_power_down();
      final_report();
   end
   // Watchdog against a hang
   initial
   begin
      #500000;
      n_mismatch++;
      final_report();
   end
endmodule
